// >>> ssbt_top.v
`include "ssbt_consts.vh"
module ssbt_top #(
  parameter SEC_CYCLES = `SSBT_SEC_CYCLES
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Configuration
  input wire [1:0] setup_src_mode,
  input wire [1:0] preset_src_mode,
  input wire [1:0] telegram_profile,
  input wire [6:0] interval_limit_s,
  input wire [2:0] timeout_reaction,
  input wire [15:0] serial_fixed_speed_one,
  input wire [15:0] serial_fixed_speed_two,
  input wire [15:0] out_freq_high_limit,
  input wire [15:0] present_out_freq,
  // Terminal side
  input wire [1:0] term_setup_bits,
  input wire [1:0] term_preset_bits,
  input wire [4:0] term_inputs,
  input wire count_pulse,
  input wire counter_stop_restart,
  input wire trip_ack,
  // Telegram side
  input wire telegram_valid,
  input wire [1:0] bus_setup_bits,
  input wire [1:0] bus_preset_bits,
  input wire bus_jog_one,
  input wire bus_jog_two,
  input wire [15:0] status_word,
  input wire [15:0] alarm_word,
  input wire [15:0] control_word,
  input wire [15:0] warning_word,
  input wire [15:0] ext_status_word,
  // Selections
  output reg [2:0] active_setup_r,
  output reg [1:0] preset_sel_r,
  output reg bus_jog_active_r,
  output reg [15:0] bus_jog_freq_r,
  // Timeout reaction
  output reg comm_stopped_r,
  output reg relay_enable_r,
  output reg freq_override_r,
  output reg [15:0] freq_target_r,
  output reg motor_stop_r,
  output reg trip_latched_r,
  // Readouts, serial port only
  output reg [4:0] din_readout_r,
  output reg [15:0] status_readout_r,
  output reg [15:0] alarm_readout_r,
  output reg [15:0] control_readout_r,
  output reg [15:0] warning_readout_r,
  output reg [15:0] ext_status_readout_r,
  output reg [31:0] pulse_count_r
);

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // ****************************************
  // Source merging
  // ****************************************
  wire [1:0] setup_merged;
  wire [1:0] preset_merged;
  // Serial preset bits count only under the native protocol.
  wire [1:0] bus_preset_eff = (telegram_profile == `SSBT_PROF_NATIVE) ? bus_preset_bits : 2'h0;
  ssbt_merge u_setup (
    .mode(setup_src_mode),
    .term_bits(term_setup_bits),
    .bus_bits(bus_setup_bits),
    .merged(setup_merged)
  );
  ssbt_merge u_preset (
    .mode(preset_src_mode),
    .term_bits(term_preset_bits),
    .bus_bits(bus_preset_eff),
    .merged(preset_merged)
  );
  wire jog_allowed = (telegram_profile == `SSBT_PROF_FIELDBUS);

  // ****************************************
  // Telegram interval timer
  // ****************************************
  // The timer counts whole seconds so that a 99 s limit needs only seven bits of elapsed time.
  reg [23:0] sec_cnt_r;
  reg [23:0] sec_cnt_nxt;
  reg [6:0] sec_elapsed_r;
  reg [6:0] sec_elapsed_nxt;
  reg [6:0] limit_eff;
  reg [2:0] react;
  reg sec_tick;
  reg expire;

  // Out-of-range settings fall back to the nearest legal limit and to no reaction.
  always @* begin
    if (interval_limit_s < `SSBT_LIMIT_MIN_S) begin
      limit_eff = `SSBT_LIMIT_MIN_S;
    end else if (interval_limit_s > `SSBT_LIMIT_MAX_S) begin
      limit_eff = `SSBT_LIMIT_MAX_S;
    end else begin
      limit_eff = interval_limit_s;
    end
    if (timeout_reaction > `SSBT_REACT_TRIP) begin
      react = `SSBT_REACT_OFF;
    end else begin
      react = timeout_reaction;
    end
    sec_tick = (sec_cnt_r == SEC_CYCLES - 1);
    expire = sec_tick && (sec_elapsed_r + 7'h01 >= limit_eff) && !comm_stopped_r;
  end

  // The timer freezes once the link is declared lost, so the reaction fires only once.
  always @* begin
    sec_cnt_nxt = sec_cnt_r;
    sec_elapsed_nxt = sec_elapsed_r;
    if (telegram_valid) begin
      sec_cnt_nxt = 24'h00_0000;
      sec_elapsed_nxt = 7'h00;
    end else if (!comm_stopped_r) begin
      if (sec_tick) begin
        sec_cnt_nxt = 24'h00_0000;
        sec_elapsed_nxt = sec_elapsed_r + 7'h01;
      end else begin
        sec_cnt_nxt = sec_cnt_r + 24'h00_0001;
      end
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_r <= 24'h00_0000;
      sec_elapsed_r <= 7'h00;
    end else if (!rst_n) begin
      sec_cnt_r <= 24'h00_0000;
      sec_elapsed_r <= 7'h00;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      sec_elapsed_r <= sec_elapsed_nxt;
    end
  end

  // ****************************************
  // Selections
  // ****************************************
  reg [2:0] active_setup_nxt;
  reg [1:0] preset_sel_nxt;
  reg bus_jog_active_nxt;
  reg [15:0] bus_jog_freq_nxt;

  always @* begin
    active_setup_nxt = {1'b0, setup_merged} + 3'h1;
    preset_sel_nxt = preset_merged;
    bus_jog_active_nxt = jog_allowed && (bus_jog_one || bus_jog_two);
    // Speed two wins when both jog requests are up, so the choice is never ambiguous.
    if (bus_jog_two) begin
      bus_jog_freq_nxt = serial_fixed_speed_two;
    end else begin
      bus_jog_freq_nxt = serial_fixed_speed_one;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      active_setup_r <= 3'h1;
      preset_sel_r <= 2'h0;
      bus_jog_active_r <= 1'b0;
      bus_jog_freq_r <= `SSBT_JOG_RESET;
    end else if (!rst_n) begin
      active_setup_r <= 3'h1;
    end else begin
      active_setup_r <= active_setup_nxt;
      preset_sel_r <= preset_sel_nxt;
      bus_jog_active_r <= bus_jog_active_nxt;
      bus_jog_freq_r <= bus_jog_freq_nxt;
    end
  end

  // ****************************************
  // Timeout reaction
  // ****************************************
  reg comm_stopped_nxt;
  reg relay_enable_nxt;
  reg freq_override_nxt;
  reg [15:0] freq_target_nxt;
  reg motor_stop_nxt;
  reg trip_latched_nxt;

  always @* begin
    comm_stopped_nxt = comm_stopped_r;
    relay_enable_nxt = relay_enable_r;
    freq_override_nxt = freq_override_r;
    freq_target_nxt = freq_target_r;
    motor_stop_nxt = motor_stop_r;
    trip_latched_nxt = trip_latched_r;
    // The clear comes first so that a trip raised in the same cycle still latches.
    if (trip_ack) begin
      trip_latched_nxt = 1'b0;
    end
    if (telegram_valid) begin
      // Fresh traffic ends the reaction; a latched trip needs its own ack.
      comm_stopped_nxt = 1'b0;
      relay_enable_nxt = 1'b1;
      freq_override_nxt = 1'b0;
      motor_stop_nxt = 1'b0;
    end else if (expire) begin
      comm_stopped_nxt = 1'b1;
      relay_enable_nxt = (react == `SSBT_REACT_OFF);
      case (react)
        `SSBT_REACT_HOLD: begin
          freq_override_nxt = 1'b1;
          freq_target_nxt = present_out_freq;
        end
        `SSBT_REACT_STOP: begin
          motor_stop_nxt = 1'b1;
        end
        `SSBT_REACT_JOG: begin
          freq_override_nxt = 1'b1;
          freq_target_nxt = serial_fixed_speed_one;
        end
        `SSBT_REACT_MAX: begin
          freq_override_nxt = 1'b1;
          freq_target_nxt = out_freq_high_limit;
        end
        `SSBT_REACT_TRIP: begin
          motor_stop_nxt = 1'b1;
          trip_latched_nxt = 1'b1;
        end
        default: begin
          freq_override_nxt = 1'b0;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      comm_stopped_r <= 1'b0;
      relay_enable_r <= 1'b1;
      freq_override_r <= 1'b0;
      freq_target_r <= 16'h0000;
      motor_stop_r <= 1'b0;
      trip_latched_r <= 1'b0;
    end else if (!rst_n) begin
      relay_enable_r <= 1'b1;
    end else begin
      comm_stopped_r <= comm_stopped_nxt;
      relay_enable_r <= relay_enable_nxt;
      freq_override_r <= freq_override_nxt;
      freq_target_r <= freq_target_nxt;
      motor_stop_r <= motor_stop_nxt;
      trip_latched_r <= trip_latched_nxt;
    end
  end

  // ****************************************
  // Readouts
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      din_readout_r <= 5'h00;
      status_readout_r <= 16'h0000;
      alarm_readout_r <= 16'h0000;
      control_readout_r <= 16'h0000;
      warning_readout_r <= 16'h0000;
      ext_status_readout_r <= 16'h0000;
    end else if (rst_n) begin
      // Input one arrives on term_inputs[0] and lands in the leftmost bit.
      din_readout_r <= {term_inputs[0], term_inputs[1], term_inputs[2], term_inputs[3], term_inputs[4]};
      status_readout_r <= status_word;
      alarm_readout_r <= alarm_word;
      control_readout_r <= control_word;
      warning_readout_r <= warning_word;
      ext_status_readout_r <= ext_status_word;
    end
  end

  // ****************************************
  // Pulse counter
  // ****************************************
  // Restart clearing beats a coincident pulse, so a pulse in the restart cycle is not counted.
  reg [31:0] pulse_count_nxt;

  always @* begin
    pulse_count_nxt = pulse_count_r;
    if (counter_stop_restart) begin
      pulse_count_nxt = 32'h0000_0000;
    end else if (count_pulse) begin
      pulse_count_nxt = pulse_count_r + 32'h0000_0001;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_count_r <= 32'h0000_0000;
    end else if (rst_n) begin
      pulse_count_r <= pulse_count_nxt;
    end
  end
endmodule // ssbt_top

// >>> ssbt_consts.vh
`ifndef SSBT_CONSTS_VH
`define SSBT_CONSTS_VH
// Contract
// - Digital mode: setup from terminal bits only
// - Serial mode: setup from telegram bits only
// - AND mode: bitwise AND, plus one
// - OR mode: bitwise OR, plus one
// - Preset ref modes; serial only under native protocol
// - Bus jog speeds only under fieldbus profile
// - Profile codes 0 fieldbus, 1 native, 2 fast
// - Telegram interval limit 1..99 s, flags stop
// - Timeout applies configured reaction code 0..5
// - Reactions 1..5 drop the output relay
// - Hold, jog, max, stop-and-trip behaviours
// - Pulse count readout counts counting input pulses
// - Readouts 515..541 only on serial port
// - Five input bits, first input leftmost
// - Pulse counter cleared on counter-stop restart

`define SSBT_SRC_DIGITAL 2'h0
`define SSBT_SRC_SERIAL 2'h1
`define SSBT_SRC_AND 2'h2
`define SSBT_SRC_OR 2'h3
`define SSBT_SRC_RESET 2'h3

`define SSBT_PROF_FIELDBUS 2'h0
`define SSBT_PROF_NATIVE 2'h1
`define SSBT_PROF_FAST 2'h2
`define SSBT_PROF_RESET 2'h1

`define SSBT_REACT_OFF 3'h0
`define SSBT_REACT_HOLD 3'h1
`define SSBT_REACT_STOP 3'h2
`define SSBT_REACT_JOG 3'h3
`define SSBT_REACT_MAX 3'h4
`define SSBT_REACT_TRIP 3'h5

`define SSBT_LIMIT_MIN_S 7'h01
`define SSBT_LIMIT_MAX_S 7'h63
`define SSBT_LIMIT_RESET_S 7'h01
// Jog default 10,0 Hz in 0.1 Hz units.
`define SSBT_JOG_RESET 16'h0064

`define SSBT_CLK_HZ 10000000
`define SSBT_SEC_CYCLES (`SSBT_CLK_HZ / 1)
`endif

// >>> ssbt_merge.v
module ssbt_merge (
  // Mode and sources
  input wire [1:0] mode,
  input wire [1:0] term_bits,
  input wire [1:0] bus_bits,
  // Merged selection
  output reg [1:0] merged
);
`include "ssbt_consts.vh"
  always @* begin
    case (mode)
      `SSBT_SRC_DIGITAL: merged = term_bits;
      `SSBT_SRC_SERIAL: merged = bus_bits;
      `SSBT_SRC_AND: merged = term_bits & bus_bits;
      default: merged = term_bits | bus_bits;
    endcase
  end
endmodule // ssbt_merge

// >>> ssbt_master.sv
module ssbt_master (
  // Clock and pacing
  input wire core_clk,
  input wire [7:0] gap,
  // Telegram strobe
  output logic telegram_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r = 8'h00;
  initial telegram_valid = 1'b0;
  // A zero gap silences the master, which is how a lost link is staged.
  always @(posedge core_clk) begin
    cnt_r <= (gap != 8'h00 && cnt_r >= gap) ? 8'h00 : cnt_r + 8'h01;
    telegram_valid <= gap != 8'h00 && cnt_r >= gap;
  end
endmodule // ssbt_master

// >>> ssbt_top_chk.sv
module ssbt_top_chk #(
  parameter SEC_CYCLES = 10
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Inputs
  input wire [1:0] setup_src_mode,
  input wire [1:0] term_setup_bits,
  input wire [1:0] bus_setup_bits,
  input wire [2:0] timeout_reaction,
  input wire counter_stop_restart,
  input wire telegram_valid,
  // Outputs
  input wire [2:0] active_setup_r,
  input wire comm_stopped_r,
  input wire relay_enable_r,
  input wire [31:0] pulse_count_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_r;
  logic ok;
  // Inputs are ignored for three edges after reset while the internal copy clears.
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  assign ok = up_r == 2'h3;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence quiet_s;
    !telegram_valid [*8];
  endsequence
  sequence lost_s;
    !comm_stopped_r ##1 comm_stopped_r;
  endsequence
  property setup_p(logic [1:0] m, logic [1:0] v);
    ok && setup_src_mode == m |=> active_setup_r == $past(v) + 3'h1;
  endproperty
  setup_dig_a: assert property (setup_p(2'h0, term_setup_bits)) else $error("setup");
  setup_ser_a: assert property (setup_p(2'h1, bus_setup_bits)) else $error("setup");
  setup_and_a: assert property (setup_p(2'h2, bus_setup_bits & term_setup_bits)) else $error("setup");
  setup_or_a: assert property (setup_p(2'h3, bus_setup_bits | term_setup_bits)) else $error("setup");
  relay_drop_a: assert property (lost_s
    |-> relay_enable_r == ($past(timeout_reaction) == 3'h0 || $past(timeout_reaction) > 3'h5)) else $error("relay");
  quiet_run_a: assert property (telegram_valid ##1 quiet_s |-> !comm_stopped_r) else $error("early stop");
  link_back_a: assert property (ok && telegram_valid |=> !comm_stopped_r && relay_enable_r) else $error("link");
  count_clr_a: assert property (ok && counter_stop_restart |=> pulse_count_r == 32'h0000_0000) else $error("clr");
endmodule // ssbt_top_chk

bind ssbt_top ssbt_top_chk #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.*);

// >>> test_setup_source_and_bus_timeout.sv
module test_setup_source_and_bus_timeout;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic count_pulse, counter_stop_restart, trip_ack, telegram_valid, bus_jog_one, bus_jog_two;
  logic bus_jog_active_r, comm_stopped_r, relay_enable_r, freq_override_r, motor_stop_r, trip_latched_r;
  logic [1:0] setup_src_mode, preset_src_mode, telegram_profile, term_setup_bits, term_preset_bits;
  logic [1:0] bus_setup_bits, bus_preset_bits, preset_sel_r, s;
  logic [2:0] timeout_reaction, active_setup_r;
  logic [4:0] term_inputs, din_readout_r, e;
  logic [6:0] interval_limit_s;
  logic [7:0] gap;
  logic [15:0] serial_fixed_speed_one, serial_fixed_speed_two, out_freq_high_limit, present_out_freq;
  logic [15:0] status_word, alarm_word, control_word, warning_word, ext_status_word, bus_jog_freq_r;
  logic [15:0] freq_target_r, status_readout_r, alarm_readout_r, control_readout_r, warning_readout_r;
  logic [15:0] ext_status_readout_r;
  logic [31:0] pulse_count_r;
  int err_count = 0;
  int check_count = 0;

  ssbt_top #(.SEC_CYCLES(10)) dut_u (.*);
  ssbt_master master_u (.core_clk(core_clk), .gap(gap), .telegram_valid(telegram_valid));
  always #50 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic complete_run;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {count_pulse, counter_stop_restart, trip_ack, bus_jog_one, bus_jog_two, term_inputs, setup_src_mode,
      preset_src_mode, term_setup_bits, term_preset_bits, bus_setup_bits, bus_preset_bits, timeout_reaction,
      status_word, alarm_word, control_word, warning_word, ext_status_word} = '0;
    {telegram_profile, interval_limit_s, gap} = 17'h0_0305;
    {serial_fixed_speed_one, serial_fixed_speed_two, out_freq_high_limit, present_out_freq} = 64'h0123_0456_0500_0321;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int v = 0; v < 64; v++) begin
      @(posedge core_clk);
      {setup_src_mode, bus_setup_bits, term_setup_bits} <= 6'(v);
      look(1);
      s = v[5] ? (v[4] ? v[3:2] | v[1:0] : v[3:2] & v[1:0]) : (v[4] ? v[3:2] : v[1:0]);
      chk("setup", active_setup_r, s + 3'h1);
    end
    for (int p = 2; p >= 0; p--) begin
      @(posedge core_clk);
      {telegram_profile, preset_src_mode, bus_preset_bits, bus_jog_one} <= {2'(p), 5'h0F};
      look(1);
      chk("preset", preset_sel_r, (p == 1) ? 3 : 0);
      chk("jog", bus_jog_active_r, p == 0);
    end
    chk("jog speed", bus_jog_freq_r, 16'h0123);
    // The limit is three seconds of ten cycles, so silence is judged at 15 and 40 cycles.
    for (int r = 0; r < 6; r++) begin
      @(posedge core_clk);
      {trip_ack, timeout_reaction, gap} <= {1'b0, 3'(r), 8'h00};
      look(15);
      chk("early", comm_stopped_r, 1'b0);
      look(25);
      e = {1'b1, r == 0, r == 1 || r == 3 || r == 4, r == 2 || r == 5, r == 5};
      chk("reaction", {comm_stopped_r, relay_enable_r, freq_override_r, motor_stop_r, trip_latched_r}, e);
      if (r == 1 || r == 3 || r == 4)
        chk("target", freq_target_r, (r == 1) ? 16'h0321 : (r == 3) ? 16'h0123 : 16'h0500);
      @(posedge core_clk);
      {trip_ack, gap} <= 9'h105;
      look(9);
      chk("back", {comm_stopped_r, relay_enable_r, trip_latched_r}, 3'h2);
    end
    @(posedge core_clk);
    {counter_stop_restart, count_pulse, term_inputs} <= 7'h41;
    {status_word, alarm_word, control_word, warning_word, ext_status_word} <= 80'h1111_2222_3333_4444_5555;
    @(posedge core_clk);
    {counter_stop_restart, count_pulse} <= 2'h1;
    repeat (7) @(posedge core_clk);
    count_pulse <= 1'b0;
    look(2);
    chk("count", pulse_count_r, 7);
    chk("inputs", din_readout_r, 5'h10);
    chk("status", status_readout_r, 16'h1111);
    chk("alarm", alarm_readout_r, 16'h2222);
    chk("control", control_readout_r, 16'h3333);
    chk("warning", warning_readout_r, 16'h4444);
    chk("ext status", ext_status_readout_r, 16'h5555);
    complete_run;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    complete_run;
  end
endmodule // test_setup_source_and_bus_timeout
